// ==== inc/vsb_consts.svh ====
// Offsets, field positions, reset values and codes of the slave bridge
`ifndef VSB_CONSTS_SVH
`define VSB_CONSTS_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses on the register port)
// ----------------------------------------------------------------
`define VSB_OFF_MISC     12'h000
`define VSB_OFF_PCSR     12'h004
`define VSB_OFF_CSRB     12'h008
`define VSB_OFF_STAT     12'h00C
`define VSB_OFF_IMG_HI   4'h1
`define VSB_IMG_CTL      2'h0
`define VSB_IMG_BASE     2'h1
`define VSB_IMG_BOUND    2'h2
`define VSB_IMG_OFFS     2'h3
// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define VSB_RST_RESCIND  1'b1
`define VSB_RST_CSRB     16'hD000
`define VSB_BIT_RESCIND  0
`define VSB_BIT_BM       2
`define VSB_BIT_EN       31
`define VSB_BIT_POSTED_WRITE_ENABLE     30
`define VSB_BIT_PREFETCH_READ_ENABLE     29
`define VSB_BIT_WIDE     28
`define VSB_BIT_LOCKED_RMW_ENABLE    27
`define VSB_BIT_PROG     15
`define VSB_BIT_DATA     14
`define VSB_BIT_SUPER    13
`define VSB_BIT_USER     12
`define VSB_VAS_LSB      16
`define VSB_PAS_LSB      0
// ----------------------------------------------------------------
// Space codes and PCI commands
// ----------------------------------------------------------------
`define VSB_VAS_A16      3'h0
`define VSB_VAS_A24      3'h1
`define VSB_VAS_A32      3'h2
`define VSB_VAS_USR1     3'h6
`define VSB_VAS_USR2     3'h7
`define VSB_AMS_A16      3'h5
`define VSB_AMS_A24      3'h7
`define VSB_AMS_A32      3'h1
`define VSB_AMS_USR1     3'h2
`define VSB_AMS_USR2     3'h3
`define VSB_PAS_MEM      2'h0
`define VSB_PAS_IO       2'h1
`define VSB_PAS_CFG      2'h2
`define VSB_CMD_IORD     4'h2
`define VSB_CMD_IOWR     4'h3
`define VSB_CMD_MRD      4'h6
`define VSB_CMD_MWR      4'h7
`define VSB_CMD_CRD      4'hA
`define VSB_CMD_CWR      4'hB
`define VSB_CMD_MRDM     4'hC
`define VSB_COARSE_CLR   4'h0
`endif

// ==== inc/vsb_pkg.sv ====
// Types shared by the slave bridge
package vsb_pkg;
  // ----------------------------------------------------------------
  // Captured PCI transaction
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic [31:0] data;
    logic        lock;
    logic        req64;
    logic        posted;
    logic        prefetch;
  } vsb_pci_req_t;
  // ----------------------------------------------------------------
  // Slave cycle states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_ISSUE, S_WAIT, S_ACK, S_REL
  } vsb_state_t;
endpackage

// ==== core/vsb_bridge.sv ====
// VME slave window decode and mapping onto PCI master requests
`include "vsb_consts.svh"
module vsb_bridge
  import vsb_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [11:0]  reg_addr_in,
  input  wire logic [31:0]  reg_wdata_in,
  input  wire logic         reg_wr_in,
  input  wire logic         reg_rd_in,
  output logic      [31:0]  reg_rdata_out,
  input  wire logic         vme_as_n_in,
  input  wire logic         vme_ds_n_in,
  input  wire logic         vme_write_n_in,
  input  wire logic [5:0]   vme_am_in,
  input  wire logic [31:0]  vme_addr_in,
  input  wire logic [31:0]  vme_data_in,
  output logic      [31:0]  vme_data_out,
  output logic              vme_data_oe_out,
  output logic              vme_dtack_n_out,
  output logic              vme_dtack_oe_out,
  output vsb_pci_req_t      pci_req_out,
  output logic              pci_valid_out,
  input  wire logic         pci_ready_in,
  input  wire logic         pci_done_in,
  input  wire logic         pci_ack64_in,
  input  wire logic [31:0]  pci_rdata_in,
  output logic              pci_lock_out,
  output logic              pci_wide_out
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0]  img_ctl_q   [4];
  logic [19:0]  img_base_q  [4];
  logic [19:0]  img_bound_q [4];
  logic [19:0]  img_offs_q  [4];
  logic         rescind_q;
  logic         bm_q;
  logic [15:0]  csrb_q;
  vsb_state_t   st_q;
  vsb_pci_req_t req_q;
  logic         lock_q;
  logic         wide_q;
  logic [31:0]  vdata_q;
  logic         vread_q;
  logic [31:0]  rdata_q;
  logic         any_hit;
  logic [1:0]   hit_idx;
  logic         csr_hit;
  logic         strobe;
  logic         blk;
  logic         we;
  logic [11:0]  waddr;
  logic [31:0]  wdata;
  logic [11:0]  raddr;
  logic [31:0]  rval;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Window field as an address, coarse images drop bits 15..12
  function automatic logic [31:0] f_gran(input logic [19:0] v,
                                         input logic [1:0]  i);
    logic [19:0] r;
    r = v;
    if (i != 2'h0) begin
      r[3:0] = `VSB_COARSE_CLR;
    end
    return {r, 12'h000};
  endfunction

  // Address modifier check against space, privilege and type
  function automatic logic f_am_ok(input logic [31:0] c,
                                   input logic [5:0]  am);
    logic [2:0] vme_space_select;
    logic [2:0] ams;
    logic       sp;
    logic       pt;
    vme_space_select = c[`VSB_VAS_LSB +: 3];
    ams = am[5:3];
    unique case (vme_space_select)
      `VSB_VAS_A16:  sp = (ams == `VSB_AMS_A16);
      `VSB_VAS_A24:  sp = (ams == `VSB_AMS_A24);
      `VSB_VAS_A32:  sp = (ams == `VSB_AMS_A32);
      `VSB_VAS_USR1: sp = (am[5:3] == `VSB_AMS_USR1);
      `VSB_VAS_USR2: sp = (am[5:3] == `VSB_AMS_USR2);
      default:       sp = 1'b0;
    endcase
    pt = (am[1:0] == 2'b10) ? c[`VSB_BIT_PROG] : c[`VSB_BIT_DATA];
    return sp && pt && (am[2] ? c[`VSB_BIT_SUPER]
                              : c[`VSB_BIT_USER]);
  endfunction

  // PCI command from space, direction and prefetch
  function automatic logic [3:0] f_cmd(input logic [1:0] pci_space_field,
                                       input logic       wr,
                                       input logic       pf);
    unique case (pci_space_field)
      `VSB_PAS_IO:  return wr ? `VSB_CMD_IOWR : `VSB_CMD_IORD;
      `VSB_PAS_CFG: return wr ? `VSB_CMD_CWR : `VSB_CMD_CRD;
      default:      return wr ? `VSB_CMD_MWR
                              : (pf ? `VSB_CMD_MRDM : `VSB_CMD_MRD);
    endcase
  endfunction

  // Register read decode shared by port and VME window
  function automatic logic [31:0] f_rd(input logic [11:0] a);
    logic [1:0] i;
    i = a[5:4];
    if (a[11:8] == `VSB_OFF_IMG_HI && a[7:6] == 2'h0) begin
      unique case (a[3:2])
        `VSB_IMG_CTL:   return img_ctl_q[i];
        `VSB_IMG_BASE:  return f_gran(img_base_q[i], i);
        `VSB_IMG_BOUND: return f_gran(img_bound_q[i], i);
        default:        return f_gran(img_offs_q[i], i);
      endcase
    end
    unique case (a)
      `VSB_OFF_MISC: return {31'h0, rescind_q};
      `VSB_OFF_PCSR: return {29'h0, bm_q, 2'h0};
      `VSB_OFF_CSRB: return {csrb_q, 16'h0000};
      `VSB_OFF_STAT: return {27'h0, wide_q, lock_q, 3'(st_q)};
      default:       return 32'h0000_0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Cycle decode
  // ----------------------------------------------------------------
  assign strobe  = !vme_as_n_in && !vme_ds_n_in;
  assign blk     = (vme_am_in[1:0] == 2'b11) || (vme_am_in[1:0] == 2'b00);
  assign csr_hit = (vme_addr_in[31:16] == csrb_q);

  always_comb begin
    any_hit = 1'b0;
    hit_idx = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (img_ctl_q[i][`VSB_BIT_EN] && bm_q
          && f_am_ok(img_ctl_q[i], vme_am_in)
          && vme_addr_in >= f_gran(img_base_q[i], 2'(i))
          && vme_addr_in < f_gran(img_bound_q[i], 2'(i))) begin
        any_hit = 1'b1;
        hit_idx = 2'(i);
      end
    end
  end

  // Register write source: port first, then VME register access
  always_comb begin
    we    = reg_wr_in;
    waddr = reg_addr_in;
    wdata = reg_wdata_in;
    if (!reg_wr_in && st_q == S_IDLE && strobe && csr_hit
        && !vme_write_n_in) begin
      we    = 1'b1;
      waddr = vme_addr_in[11:0];
      wdata = vme_data_in;
    end
  end

  assign raddr = vme_addr_in[11:0];
  assign rval  = f_rd(raddr);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rescind_q <= `VSB_RST_RESCIND;
      bm_q      <= 1'b0;
      csrb_q    <= `VSB_RST_CSRB;
      for (int i = 0; i < 4; i++) begin
        img_ctl_q[i]   <= 32'h0000_0000;
        img_base_q[i]  <= 20'h0_0000;
        img_bound_q[i] <= 20'h0_0000;
        img_offs_q[i]  <= 20'h0_0000;
      end
    end else if (we) begin
      if (waddr[11:8] == `VSB_OFF_IMG_HI && waddr[7:6] == 2'h0) begin
        unique case (waddr[3:2])
          `VSB_IMG_CTL:   img_ctl_q[waddr[5:4]]   <= wdata;
          `VSB_IMG_BASE:  img_base_q[waddr[5:4]]  <= wdata[31:12];
          `VSB_IMG_BOUND: img_bound_q[waddr[5:4]] <= wdata[31:12];
          default:        img_offs_q[waddr[5:4]]  <= wdata[31:12];
        endcase
      end else if (waddr == `VSB_OFF_MISC) begin
        rescind_q <= wdata[`VSB_BIT_RESCIND];
      end else if (waddr == `VSB_OFF_PCSR) begin
        bm_q <= wdata[`VSB_BIT_BM];
      end else if (waddr == `VSB_OFF_CSRB) begin
        csrb_q <= wdata[31:16];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      rdata_q <= f_rd(reg_addr_in);
    end
  end
  assign reg_rdata_out = rdata_q;

  // ----------------------------------------------------------------
  // Slave cycle sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q    <= S_IDLE;
      req_q   <= '0;
      vdata_q <= 32'h0000_0000;
      vread_q <= 1'b0;
    end else begin
      unique case (st_q)
        S_IDLE: begin
          if (strobe && csr_hit) begin
            st_q    <= S_ACK;
            vread_q <= vme_write_n_in;
            vdata_q <= rval;
          end else if (strobe && any_hit) begin
            st_q          <= S_ISSUE;
            vread_q       <= vme_write_n_in;
            req_q.addr    <= vme_addr_in
                             + {img_offs_q[hit_idx], 12'h000};
            req_q.data    <= vme_data_in;
            req_q.lock    <= img_ctl_q[hit_idx][`VSB_BIT_LOCKED_RMW_ENABLE]
                             && vme_write_n_in && !blk;
            req_q.req64   <= img_ctl_q[hit_idx][`VSB_BIT_WIDE];
            req_q.posted  <= img_ctl_q[hit_idx][`VSB_BIT_POSTED_WRITE_ENABLE]
                             && !vme_write_n_in
                             && img_ctl_q[hit_idx][1:0] == `VSB_PAS_MEM;
            req_q.prefetch <= img_ctl_q[hit_idx][`VSB_BIT_PREFETCH_READ_ENABLE]
                             && vme_write_n_in && blk;
            req_q.cmd     <= f_cmd(img_ctl_q[hit_idx][1:0],
                                   !vme_write_n_in,
                                   img_ctl_q[hit_idx][`VSB_BIT_PREFETCH_READ_ENABLE]
                                   && vme_write_n_in && blk);
          end
        end
        S_ISSUE: begin
          if (pci_ready_in) begin
            st_q <= req_q.posted ? S_ACK : S_WAIT;
          end
        end
        S_WAIT: begin
          if (pci_done_in) begin
            st_q    <= S_ACK;
            vdata_q <= pci_rdata_in;
          end
        end
        S_ACK: begin
          if (vme_ds_n_in) begin
            st_q <= S_REL;
          end
        end
        S_REL: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // PCI lock ownership follows the VME address strobe
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lock_q <= 1'b0;
    end else if (st_q == S_ISSUE && req_q.lock) begin
      lock_q <= 1'b1;
    end else if (vme_as_n_in) begin
      lock_q <= 1'b0;
    end
  end

  // Data path width agreed by the target
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wide_q <= 1'b0;
    end else if (st_q == S_WAIT && pci_done_in) begin
      wide_q <= req_q.req64 && pci_ack64_in;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pci_req_out      = req_q;
  assign pci_valid_out    = (st_q == S_ISSUE);
  assign pci_lock_out     = lock_q || (st_q == S_ISSUE && req_q.lock);
  assign pci_wide_out     = wide_q;
  assign vme_data_out     = vdata_q;
  assign vme_data_oe_out  = (st_q == S_ACK) && vread_q;
  assign vme_dtack_n_out  = (st_q != S_ACK);
  assign vme_dtack_oe_out = (st_q == S_ACK)
                            || (st_q == S_REL && rescind_q);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_lock_hold;
    @(posedge clk_in) disable iff (rst_in)
      pci_lock_out && !vme_as_n_in |=> pci_lock_out;
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("PCI lock dropped while address strobe low");

  property p_lock_single;
    @(posedge clk_in) disable iff (rst_in)
      pci_valid_out && pci_req_out.lock
        |-> !pci_req_out.posted && !pci_req_out.prefetch
            && pci_req_out.cmd != `VSB_CMD_MRDM;
  endproperty
  a_lock_single: assert property (p_lock_single)
    else $error("Locked read not coupled single beat");

  property p_post_mem;
    @(posedge clk_in) disable iff (rst_in)
      pci_valid_out && pci_req_out.posted
        |-> pci_req_out.cmd == `VSB_CMD_MWR;
  endproperty
  a_post_mem: assert property (p_post_mem)
    else $error("Posted request is not a memory write");

  property p_rescind;
    @(posedge clk_in) disable iff (rst_in)
      st_q == S_ACK && vme_ds_n_in
        |=> vme_dtack_oe_out == $past(rescind_q) && vme_dtack_n_out
            ##1 !vme_dtack_oe_out;
  endproperty
  a_rescind: assert property (p_rescind)
    else $error("DTACK release not as programmed");

  property p_no_hit;
    @(posedge clk_in) disable iff (rst_in)
      st_q == S_IDLE && strobe && !any_hit && !csr_hit
        |=> !vme_dtack_oe_out && !vme_data_oe_out && !pci_valid_out;
  endproperty
  a_no_hit: assert property (p_no_hit)
    else $error("Response to an unmatched cycle");

  property p_wide;
    @(posedge clk_in) disable iff (rst_in)
      st_q == S_WAIT && pci_done_in
        |=> pci_wide_out == $past(pci_ack64_in && req_q.req64);
  endproperty
  a_wide: assert property (p_wide)
    else $error("Data path width not taken from acknowledge");

  property p_bm_gate;
    @(posedge clk_in) disable iff (rst_in)
      !bm_q && st_q == S_IDLE && !csr_hit |=> st_q != S_ISSUE;
  endproperty
  a_bm_gate: assert property (p_bm_gate)
    else $error("Image answered with bus master disabled");

  property p_csr_first;
    @(posedge clk_in) disable iff (rst_in)
      st_q == S_IDLE && strobe && csr_hit |=> st_q == S_ACK;
  endproperty
  a_csr_first: assert property (p_csr_first)
    else $error("Register window access sent to PCI");

  property p_posted_ack;
    @(posedge clk_in) disable iff (rst_in)
      pci_valid_out && pci_ready_in && pci_req_out.posted
        |=> st_q == S_ACK && !vme_dtack_n_out;
  endproperty
  a_posted_ack: assert property (p_posted_ack)
    else $error("Posted write not acknowledged at once");
endmodule

// ==== verif/vsb_pci_target.sv ====
// PCI target stand-in that answers the bridge's master requests
module vsb_pci_target
  import vsb_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire vsb_pci_req_t req_in,
  input  wire logic         valid_in,
  input  wire logic [1:0]   stall_in,
  input  wire logic         ack64_en_in,
  output logic              ready_out = 1'b0,
  output logic              done_out = 1'b0,
  output logic              ack64_out = 1'b0,
  output logic [31:0]       rdata_out = 32'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] st_q = 2'h0;
  logic [1:0] cnt_q = 2'h0;
  // ----------------------------------------------------------------
  // Accept after a stall, then finish coupled requests
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    ready_out <= 1'b0;
    done_out <= 1'b0;
    ack64_out <= 1'b0;
    rdata_out <= rdata_out + 32'h1357_9BDF;
    if (rst_in) begin
      st_q <= 2'h0;
    end else begin
      case (st_q)
        2'h0: if (valid_in) begin
          cnt_q <= stall_in;
          st_q <= 2'h1;
        end
        2'h1: if (cnt_q == 2'h0) begin
          ready_out <= 1'b1;
          st_q <= 2'h2;
        end else cnt_q <= cnt_q - 2'h1;
        2'h2: begin
          cnt_q <= stall_in;
          st_q <= req_in.posted ? 2'h0 : 2'h3;
        end
        default: if (cnt_q == 2'h0) begin
          done_out <= 1'b1;
          ack64_out <= ack64_en_in & req_in.req64;
          rdata_out <= ~req_in.addr;
          st_q <= 2'h0;
        end else cnt_q <= cnt_q - 2'h1;
      endcase
    end
  end
endmodule

// ==== verif/test_vme_slave_pci_bridge.sv ====
// Self-checking bench of the slave bridge
`include "vsb_consts.svh"
module test_vme_slave_pci_bridge
  import vsb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clk_in = 1'b0;
  logic         rst_in = 1'b1;
  logic [11:0]  reg_addr = 12'h0;
  logic [31:0]  reg_wdata = 32'h0;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic [31:0]  reg_rdata;
  logic         as_n = 1'b1;
  logic         ds_n = 1'b1;
  logic         wr_n = 1'b1;
  logic [5:0]   am = 6'h0;
  logic [31:0]  vaddr = 32'h0;
  logic [31:0]  vdata = 32'h0;
  logic [31:0]  vq;
  logic         vq_oe;
  logic         dtack_n;
  logic         dtack_oe;
  vsb_pci_req_t req;
  logic         valid;
  logic         ready;
  logic         done;
  logic         ack64;
  logic         lock;
  logic         wide;
  logic         ack64_en = 1'b0;
  logic [1:0]   stall = 2'h0;
  logic [31:0]  prdata;
  logic [31:0]  exp_q[$];
  logic [31:0]  seed = 32'h5610;
  logic         rescind = 1'b1;
  logic         rd_d = 1'b0;
  logic         ack_d = 1'b0;
  int           miscompares = 0;
  int           comparisons = 0;
  logic [2:0]   vas_t[5] = '{`VSB_VAS_A16, `VSB_VAS_A24, `VSB_VAS_A32,
                             `VSB_VAS_USR1, `VSB_VAS_USR2};
  logic [5:0]   am_t[5] = '{6'h2D, 6'h3D, 6'h0D, 6'h15, 6'h1D};
  logic [3:0]   rc_t[3] = '{`VSB_CMD_MRD, `VSB_CMD_IORD, `VSB_CMD_CRD};
  logic [3:0]   wc_t[3] = '{`VSB_CMD_MWR, `VSB_CMD_IOWR, `VSB_CMD_CWR};

  always #50 clk_in = ~clk_in;

  vsb_bridge dut_u (.clk_in(clk_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .vme_as_n_in(as_n),
    .vme_ds_n_in(ds_n), .vme_write_n_in(wr_n), .vme_am_in(am),
    .vme_addr_in(vaddr), .vme_data_in(vdata), .vme_data_out(vq),
    .vme_data_oe_out(vq_oe), .vme_dtack_n_out(dtack_n),
    .vme_dtack_oe_out(dtack_oe), .pci_req_out(req), .pci_valid_out(valid),
    .pci_ready_in(ready), .pci_done_in(done), .pci_ack64_in(ack64),
    .pci_rdata_in(prdata), .pci_lock_out(lock), .pci_wide_out(wide));

  vsb_pci_target tgt_u (.clk_in(clk_in), .rst_in(rst_in), .req_in(req),
    .valid_in(valid), .stall_in(stall), .ack64_en_in(ack64_en),
    .ready_out(ready), .done_out(done), .ack64_out(ack64),
    .rdata_out(prdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [11:0] ia(input logic [1:0] i,
                                     input logic [1:0] s);
    return {`VSB_OFF_IMG_HI, 2'b00, i, s, 2'b00};
  endfunction
  function automatic logic [31:0] cw(input logic [4:0] f,
                                     input logic [2:0] v,
                                     input logic [1:0] p);
    return {f, 8'h00, v, 4'hF, 10'h000, p};
  endfunction
  task automatic chk(input string nm, input logic [39:0] s,
                     input logic [39:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic pop(input string nm, input logic [31:0] s);
    logic [31:0] e;
    e = 32'hXXXX_XXXX;
    if (exp_q.size() != 0) e = exp_q.pop_front();
    chk(nm, 40'(s), 40'(e));
  endtask
  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic rw(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_in);
    reg_wr <= 1'b0;
  endtask
  task automatic rr(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_in);
    reg_rd <= 1'b0;
  endtask
  task automatic img(input logic [1:0] i, input logic [31:0] b, bd, o, c);
    rw(ia(i, `VSB_IMG_BASE), b);
    rw(ia(i, `VSB_IMG_BOUND), bd);
    rw(ia(i, `VSB_IMG_OFFS), o);
    rw(ia(i, `VSB_IMG_CTL), c);
  endtask
  // k: 0 no hit, 1 register hit (rq[39:8] read data), 2 PCI request
  task automatic vme(input logic w, input logic [5:0] m,
                     input logic [31:0] a, input logic [1:0] k,
                     input logic [39:0] rq, input logic hold);
    logic [31:0] d;
    int n;
    d = rnd();
    n = 0;
    if (!w && k == 2'd1) exp_q.push_back(rq[39:8]);
    if (!w && k == 2'd2) exp_q.push_back(~rq[39:8]);
    @(posedge clk_in);
    stall <= 2'(rnd());
    am <= m;
    vaddr <= a;
    vdata <= d;
    wr_n <= ~w;
    as_n <= 1'b0;
    ds_n <= 1'b0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (dtack_n !== 1'b0 && n < 40);
    chk("dtack_oe", 40'(dtack_oe), 40'(k != 2'd0));
    chk("valid", 40'(valid), 40'h0);
    if (k == 2'd2) begin
      chk("req", {req.addr, req.cmd, req.lock, req.req64, req.posted,
                  req.prefetch}, rq);
      if (w) chk("wdata", 40'(req.data), 40'(d));
      if (!rq[1]) chk("wide", 40'(wide), 40'(rq[2] & ack64_en));
    end
    @(posedge clk_in);
    ds_n <= 1'b1;
    as_n <= ~hold;
    @(posedge clk_in);
    #1;
    if (k != 2'd0) begin
      chk("rel_oe", 40'(dtack_oe), 40'(rescind));
      chk("rel_n", 40'(dtack_n), 40'h1);
    end
    if (hold) begin
      repeat (3) @(posedge clk_in);
      #1;
      chk("lock_held", 40'(lock), 40'h1);
      @(posedge clk_in);
      as_n <= 1'b1;
      repeat (2) @(posedge clk_in);
      #1;
      chk("lock_free", 40'(lock), 40'h0);
    end
  endtask

  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    rd_d <= reg_rd;
    ack_d <= ~dtack_n & vq_oe;
  end
  always @(negedge clk_in) begin
    if (rd_d) pop("reg_rdata", reg_rdata);
    if (~dtack_n & vq_oe & ~ack_d) pop("vme_data", vq);
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    rr(`VSB_OFF_MISC, 32'h1);
    rr(`VSB_OFF_PCSR, 32'h0);
    rr(`VSB_OFF_CSRB, 32'hD000_0000);
    for (int i = 0; i < 4; i++) rr(ia(2'(i), `VSB_IMG_CTL), 32'h0);
    rr(12'hFF0, 32'h0);
    $display("test reset done");
    img(2'd0, 32'h1000_0000, 32'h2000_0000, 32'hF000_0000,
        cw(5'h10, `VSB_VAS_A32, `VSB_PAS_MEM));
    vme(1'b0, 6'h0D, 32'h1000_0010, 2'd0, 40'h0, 1'b0);
    rw(`VSB_OFF_PCSR, 32'h4);
    rr(`VSB_OFF_PCSR, 32'h4);
    vme(1'b0, 6'h0D, 32'h1000_0010, 2'd2,
        {32'h0000_0010, `VSB_CMD_MRD, 4'h0}, 1'b0);
    vme(1'b0, 6'h0D, 32'h0FFF_FFFC, 2'd0, 40'h0, 1'b0);
    vme(1'b0, 6'h0D, 32'h2000_0000, 2'd0, 40'h0, 1'b0);
    vme(1'b0, 6'h3D, 32'h1000_0010, 2'd0, 40'h0, 1'b0);
    rw(ia(2'd0, `VSB_IMG_CTL),
       cw(5'h10, `VSB_VAS_A32, `VSB_PAS_MEM) & 32'hFFFF_5FFF);
    vme(1'b0, 6'h0A, 32'h1000_0010, 2'd0, 40'h0, 1'b0);
    vme(1'b0, 6'h09, 32'h1000_0030, 2'd2,
        {32'h0000_0030, `VSB_CMD_MRD, 4'h0}, 1'b0);
    $display("test decode done");
    for (int s = 0; s < 5; s++) begin
      rw(ia(2'd0, `VSB_IMG_CTL), cw(5'h18, vas_t[s], 2'(s % 3)));
      vme(1'b0, am_t[s], 32'h1000_0020, 2'd2,
          {32'h0000_0020, rc_t[s % 3], 4'h0}, 1'b0);
      vme(1'b1, am_t[s], 32'h1000_0024, 2'd2,
          {32'h0000_0024, wc_t[s % 3], 2'b00, s % 3 == 0, 1'b0},
          1'b0);
    end
    $display("test spaces done");
    rw(ia(2'd1, `VSB_IMG_BASE), 32'h3001_F000);
    rr(ia(2'd1, `VSB_IMG_BASE), 32'h3001_0000);
    img(2'd1, 32'h3000_0000, 32'h4000_0000, 32'h0,
        cw(5'h1F, `VSB_VAS_A32, `VSB_PAS_MEM));
    ack64_en <= 1'b1;
    vme(1'b0, 6'h0D, 32'h3000_0100, 2'd2,
        {32'h3000_0100, `VSB_CMD_MRD, 4'hC}, 1'b1);
    ack64_en <= 1'b0;
    vme(1'b0, 6'h0D, 32'h3000_0104, 2'd2,
        {32'h3000_0104, `VSB_CMD_MRD, 4'hC}, 1'b0);
    vme(1'b0, 6'h0F, 32'h3000_0200, 2'd2,
        {32'h3000_0200, `VSB_CMD_MRDM, 4'h5}, 1'b0);
    vme(1'b1, 6'h0D, 32'h3000_0300, 2'd2,
        {32'h3000_0300, `VSB_CMD_MWR, 4'h6}, 1'b0);
    $display("test locked done");
    img(2'd2, 32'hD000_0000, 32'hE000_0000, 32'h0,
        cw(5'h10, `VSB_VAS_A32, `VSB_PAS_MEM));
    vme(1'b0, 6'h0D, 32'hD000_0000, 2'd1, {32'h1, 8'h0}, 1'b0);
    rw(`VSB_OFF_MISC, 32'h0);
    rescind = 1'b0;
    vme(1'b0, 6'h0D, 32'hD000_0000, 2'd1, {32'h0, 8'h0}, 1'b0);
    $display("test register window done");
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    wrap_up();
  end
endmodule
